// [src/adcd_pkg.sv]
// constants, field layouts and carrier types for the converter support logic
package adcd_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int STARTUP_NS = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_GOOD = 8'h00;
  localparam int CMD_RD_BIT = 6;
  localparam logic [1:0] CRC_OFF = 2'h0;
  localparam logic [1:0] CRC_XOR = 2'h1;
  localparam logic [1:0] CRC_POLYNOMIAL = 2'h2;
  localparam int AI_START = 0;
  localparam int AI_UVLO = 1;
  localparam int AI_RAILP = 2;
  localparam int AI_RAILA = 6;
  localparam int AI_REF300 = 10;
  localparam int AI_REF3 = 11;
  localparam int AI_PA = 12;
  localparam int AI_PB = 13;
  localparam int AI_CS = 14;
  localparam int AI_N = 15;
  localparam int PC_A_OE = 0;
  localparam int PC_B_OE = 1;
  localparam int PC_C_EN = 2;
  localparam int PC_D_EN = 3;
  localparam int PC_A_IE = 4;
  localparam int PC_B_IE = 5;
  localparam int PC_ERR = 6;
  localparam logic [1:0] ERR_OFF = 2'h0;
  localparam logic [1:0] ERR_FAULT = 2'h1;
  localparam logic [1:0] ERR_GPO = 2'h2;
  localparam int PD_A = 0;
  localparam int PD_B = 1;
  localparam int PD_C = 2;
  localparam int PD_D = 3;
  localparam int PD_ERR = 4;
  localparam logic POR_RST = 1'b1;
  typedef enum {S_IDLE, S_CONV} adcd_state_e;
  typedef struct packed {
    logic power_on_flag;
    logic undervoltage_flag;
    logic ready;
    logic [1:0] pos_output_rail_flag;
    logic [1:0] neg_output_rail_flag;
    logic ref_low;
    logic range_err;
    logic reg_err;
    logic crc_err;
  } adcd_flags_s;
  typedef struct packed {
    logic a_o, a_oe, b_o, b_oe, c_o, c_oe, d_o, d_oe;
    logic err_o, err_oe, a_rd, b_rd, sw;
  } adcd_pins_s;
  function automatic logic [7:0] adcd_crc8(input logic [7:0] c, input logic b);
    adcd_crc8 = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction
endpackage

// [src/adcd_top.sv]
// chop sequencer, latched status flags, pin control and serial checksums
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1: with chop on, average a normal and a swapped-polarity conversion
// RULE2: continuous chop: first result after two conversions, then one per conversion
// RULE3: host enables internal reference when excitation currents are used
// RULE4: host sets gain 4 when reading the temperature sensor
// RULE5: power-on flag set by reset, held until cleared by host
// RULE6: undervoltage flag set when the supply detector trips
// RULE7: ready flag raised once startup is done
// RULE8: four rail flags, over and under for each amplifier output
// RULE9: rail faults latched in a conversion, shown only at its end
// RULE10: rail flags follow converter input when amplifier is bypassed
// RULE11: reference-low flag latched after each conversion, selected threshold
// RULE12: output code forced to zeros on underrange, ones on overrange
// RULE13: range error set on out-of-range, cleared once condition is gone
// RULE14: integrity error when register image differs from value at activation
// RULE15: two bidirectional and two output-only pins, enabled by pin control
// RULE16: error pin may act as a plain output
// RULE17: bridge switch follows its control bit
// RULE18: bad write checksum sets error flag, data not applied
// RULE19: host reads back written registers to confirm them
// RULE20: write checksum over command and 8 to 24 data bits, polynomial
// RULE21: read checksum over command and 8 to 32 bits, polynomial or xor
// RULE22: every transfer ends with an 8-bit checksum; code expects none when CRC_MODE is CRC_OFF
// RULE23: conversion starts at start pin rise or start command
// RULE24: checksum starts at zero, msb first; xor is bytewise
// RULE25: comparator inputs synchronised before latching
module adcd_top
  import adcd_pkg::*;
#(
  parameter int CW = 24,
  parameter int RW = 64
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic LINK_CS_N,
  input wire logic LINK_DIN,
  input wire logic LINK_DOUT,
  output logic [7:0] LINK_RD_CRC,
  input wire logic [1:0] CRC_MODE,
  input wire logic CHOP_EN,
  input wire logic CONT_MODE,
  input wire logic START_PIN,
  input wire logic START_CMD,
  output logic CONV_GO,
  output logic CONV_SWAP,
  input wire logic CONV_DONE,
  input wire logic [CW-1:0] CONV_CODE,
  input wire logic CONV_OVER,
  input wire logic CONV_UNDER,
  output logic [CW-1:0] RESULT,
  output logic RESULT_VALID,
  input wire logic UVLO_DET,
  input wire logic [3:0] RAIL_PGA,
  input wire logic [3:0] RAIL_ADC,
  input wire logic AMP_BYPASS,
  input wire logic REF_LOW_300,
  input wire logic REF_LOW_THIRD,
  input wire logic REF_MON_EN,
  input wire logic REF_THR_SEL,
  input wire logic POR_CLR,
  input wire logic UVLO_CLR,
  input wire logic CRC_ERR_CLR,
  input wire logic REG_CHECK_EN,
  input wire logic [RW-1:0] REG_IMAGE,
  output adcd_flags_s FLAGS,
  output logic WR_APPLY,
  output logic [7:0] WR_CMD,
  output logic [23:0] WR_DATA,
  output logic [1:0] WR_LEN,
  input wire logic [7:0] PIN_CONTROL_REGISTER,
  input wire logic [4:0] PIN_DATA,
  input wire logic BIDIR_PIN_A_I,
  output logic BIDIR_PIN_A_O,
  output logic BIDIR_PIN_A_OE,
  input wire logic BIDIR_PIN_B_I,
  output logic BIDIR_PIN_B_O,
  output logic BIDIR_PIN_B_OE,
  output logic PIN_A_READ,
  output logic PIN_B_READ,
  output logic OUT_PIN_C,
  output logic OUT_PIN_C_OE,
  output logic OUT_PIN_D,
  output logic OUT_PIN_D_OE,
  output logic ERR_PIN_O,
  output logic ERR_PIN_OE,
  input wire logic BRIDGE_SWITCH_CONTROL,
  output logic SWITCHED_GROUND_PIN_CLOSE
);

  typedef struct packed {
    logic [AI_N-1:0] s1;
    logic [AI_N-1:0] s2;
    logic [AI_N-1:0] s3;
    logic [AI_N-1:0] f;
    adcd_state_e st;
    logic start_p;
    logic cs_p;
    logic have_prev;
    logic swap;
    logic go;
    logic res_v;
    logic [CW-1:0] prev;
    logic [CW-1:0] res;
    logic [3:0] pend;
    adcd_flags_s fl;
    logic [15:0] su;
    logic rc_p;
    logic [7:0] snap;
    logic wr_ap;
    logic [7:0] wr_cmd;
    logic [23:0] wr_data;
    logic [1:0] wr_len;
    adcd_pins_s pins;
  } adcd_core_s;

  typedef struct packed {
    logic [1:0] m1;
    logic [1:0] m2;
    logic [5:0] cnt;
    logic [39:0] sh;
    logic [7:0] crc_w;
    logic [7:0] crc_r;
    logic [7:0] bb;
    logic [7:0] xacc;
    logic [7:0] rd_crc;
  } adcd_link_s;

  adcd_core_s q, d;
  adcd_link_s l, b, ld;
  logic fresh_q;
  logic rb;
  logic [AI_N-1:0] ain;
  logic [CW-1:0] code_f;
  logic [CW:0] sum;
  logic [CW-1:0] avg;
  logic start_ev;
  logic [3:0] rail_src;
  logic crc_on, is_rd, fr_end, len_ok, crc_ok;
  logic [5:0] ncrc, nb;
  logic [39:0] fsh, dsh;
  logic [7:0] img_crc;
  logic any_err;

  function automatic logic [7:0] img_sig(input logic [RW-1:0] v);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = RW - 1; i >= 0; i--) begin
      c = adcd_crc8(c, v[i]);
    end
    return c;
  endfunction

  assign ain = {LINK_CS_N, BIDIR_PIN_B_I, BIDIR_PIN_A_I, REF_LOW_THIRD, REF_LOW_300,
                RAIL_ADC, RAIL_PGA, UVLO_DET, START_PIN};
  assign code_f = CONV_UNDER ? '0 : (CONV_OVER ? '1 : CONV_CODE); // RULE12
  assign sum = {1'b0, q.prev} + {1'b0, code_f};
  assign avg = sum[CW:1]; // RULE1
  assign start_ev = (q.f[AI_START] & ~q.start_p) | START_CMD; // RULE23
  assign rail_src = AMP_BYPASS ? q.f[AI_RAILA+:4] : q.f[AI_RAILP+:4]; // RULE10
  // frame results are read only after the link clock has stopped with cs high
  assign crc_on = CRC_MODE != CRC_OFF;
  assign ncrc = crc_on ? 6'h08 : 6'h00;
  assign nb = l.cnt - ncrc;
  assign len_ok = (nb == 6'h10) || (nb == 6'h18) || (nb == 6'h20); // RULE20
  assign fsh = l.sh >> (l.cnt - 6'h08);
  assign dsh = l.sh >> ncrc;
  assign is_rd = fsh[CMD_RD_BIT];
  assign fr_end = q.f[AI_CS] & ~q.cs_p;
  assign crc_ok = !crc_on || (l.crc_w == CRC_GOOD); // RULE22
  assign img_crc = img_sig(REG_IMAGE);
  assign any_err = q.fl.range_err | q.fl.crc_err | q.fl.reg_err | q.fl.ref_low;

  always_comb begin
    d = q;
    d.s1 = ain;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3)); // RULE25
    d.start_p = q.f[AI_START];
    d.cs_p = q.f[AI_CS];
    d.go = 1'b0;
    d.res_v = 1'b0;
    d.wr_ap = 1'b0;
    // chop sequencer; a start always restarts the pair
    if (start_ev) begin
      d.st = S_CONV; // RULE23
      d.go = 1'b1;
      d.swap = 1'b0;
      d.have_prev = 1'b0;
    end else if (q.st == S_CONV && CONV_DONE) begin
      if (!CHOP_EN) begin
        d.res = code_f; // RULE12
        d.res_v = 1'b1;
        d.go = CONT_MODE;
        d.st = CONT_MODE ? S_CONV : S_IDLE;
      end else begin
        if (q.have_prev) begin
          d.res = avg; // RULE1
          d.res_v = 1'b1;
        end
        d.prev = code_f;
        d.have_prev = 1'b1;
        d.swap = ~q.swap; // RULE1
        d.go = CONT_MODE | ~q.have_prev; // RULE2
        d.st = (CONT_MODE | ~q.have_prev) ? S_CONV : S_IDLE;
      end
    end
    // status flags
    if (POR_CLR) d.fl.power_on_flag = 1'b0; // RULE5
    if (UVLO_CLR) d.fl.undervoltage_flag = 1'b0;
    if (q.f[AI_UVLO]) d.fl.undervoltage_flag = 1'b1; // RULE6
    if (q.su != 16'(STARTUP_CYC)) d.su = q.su + 16'h0001;
    else d.fl.ready = 1'b1; // RULE7
    d.pend = q.pend | rail_src; // RULE9
    if (CONV_DONE) begin
      d.pend = 4'h0;
      {d.fl.neg_output_rail_flag, d.fl.pos_output_rail_flag} = q.pend | rail_src; // RULE8 RULE9
      d.fl.ref_low = REF_MON_EN & (REF_THR_SEL ? q.f[AI_REF3] : q.f[AI_REF300]); // RULE11
      d.fl.range_err = CONV_OVER | CONV_UNDER; // RULE13
    end
    // register integrity
    d.rc_p = REG_CHECK_EN;
    if (REG_CHECK_EN && !q.rc_p) d.snap = img_crc;
    if (!REG_CHECK_EN) d.fl.reg_err = 1'b0;
    else if (q.rc_p && img_crc != q.snap) d.fl.reg_err = 1'b1; // RULE14
    // write frames
    if (CRC_ERR_CLR) d.fl.crc_err = 1'b0;
    if (fr_end && !is_rd && l.cnt >= 6'h10) begin
      if (len_ok && crc_ok) begin
        d.wr_ap = 1'b1;
        d.wr_cmd = fsh[7:0];
        // trim the command byte that sits above short data
        d.wr_data = dsh[23:0] & (24'hffffff >> (6'h20 - nb));
        d.wr_len = 2'(nb[5:3] - 3'h2);
      end else if (crc_on) begin
        d.fl.crc_err = 1'b1; // RULE18
      end
    end
    // pins
    d.pins.a_oe = PIN_CONTROL_REGISTER[PC_A_OE]; // RULE15
    d.pins.a_o = PIN_DATA[PD_A];
    d.pins.b_oe = PIN_CONTROL_REGISTER[PC_B_OE];
    d.pins.b_o = PIN_DATA[PD_B];
    d.pins.a_rd = PIN_CONTROL_REGISTER[PC_A_IE] & q.f[AI_PA];
    d.pins.b_rd = PIN_CONTROL_REGISTER[PC_B_IE] & q.f[AI_PB];
    d.pins.c_oe = PIN_CONTROL_REGISTER[PC_C_EN];
    d.pins.c_o = PIN_DATA[PD_C];
    d.pins.d_oe = PIN_CONTROL_REGISTER[PC_D_EN];
    d.pins.d_o = PIN_DATA[PD_D];
    // pin has a pull-up, so a fault only ever drives it low
    unique case (PIN_CONTROL_REGISTER[PC_ERR+:2])
      ERR_GPO: begin
        d.pins.err_oe = 1'b1; // RULE16
        d.pins.err_o = PIN_DATA[PD_ERR];
      end
      ERR_FAULT: begin
        d.pins.err_oe = any_err;
        d.pins.err_o = 1'b0;
      end
      default: begin
        d.pins.err_oe = 1'b0;
        d.pins.err_o = 1'b0;
      end
    endcase
    d.pins.sw = BRIDGE_SWITCH_CONTROL; // RULE17
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
      q.st <= S_IDLE;
      q.f <= {1'b1, {(AI_N-1){1'b0}}};
      q.s1 <= {1'b1, {(AI_N-1){1'b0}}};
      q.s2 <= {1'b1, {(AI_N-1){1'b0}}};
      q.s3 <= {1'b1, {(AI_N-1){1'b0}}};
      q.cs_p <= 1'b1;
      q.fl.power_on_flag <= POR_RST; // RULE5
    end else begin
      q <= d;
    end
  end

  // link side; cs high marks the next edge as the first of a frame
  always_ff @(posedge LINK_CLK or posedge LINK_CS_N or negedge RST_N) begin
    if (!RST_N || LINK_CS_N) fresh_q <= 1'b1;
    else fresh_q <= 1'b0;
  end

  always_comb begin
    b = l;
    if (fresh_q) begin
      b.cnt = 6'h00;
      b.crc_w = CRC_INIT; // RULE24
      b.crc_r = CRC_INIT;
      b.xacc = 8'h00;
    end
    rb = (b.cnt < 6'h08) ? LINK_DIN : LINK_DOUT;
    ld = b;
    ld.m1 = CRC_MODE;
    ld.m2 = l.m1;
    ld.cnt = (b.cnt == 6'h3f) ? b.cnt : b.cnt + 6'h01;
    ld.sh = {b.sh[38:0], LINK_DIN};
    ld.crc_w = adcd_crc8(b.crc_w, LINK_DIN); // RULE20 RULE24
    ld.crc_r = adcd_crc8(b.crc_r, rb); // RULE21
    ld.bb = {b.bb[6:0], rb};
    if (b.cnt[2:0] == 3'h7) ld.xacc = b.xacc ^ ld.bb; // RULE24
    ld.rd_crc = (l.m2 == CRC_XOR) ? ld.xacc : ld.crc_r; // RULE21 RULE22
  end

  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) l <= '0;
    else l <= ld;
  end

  assign LINK_RD_CRC = l.rd_crc;
  assign CONV_GO = q.go;
  assign CONV_SWAP = q.swap;
  assign RESULT = q.res;
  assign RESULT_VALID = q.res_v;
  assign FLAGS = q.fl;
  assign WR_APPLY = q.wr_ap;
  assign WR_CMD = q.wr_cmd;
  assign WR_DATA = q.wr_data;
  assign WR_LEN = q.wr_len;
  assign BIDIR_PIN_A_O = q.pins.a_o;
  assign BIDIR_PIN_A_OE = q.pins.a_oe;
  assign BIDIR_PIN_B_O = q.pins.b_o;
  assign BIDIR_PIN_B_OE = q.pins.b_oe;
  assign PIN_A_READ = q.pins.a_rd;
  assign PIN_B_READ = q.pins.b_rd;
  assign OUT_PIN_C = q.pins.c_o;
  assign OUT_PIN_C_OE = q.pins.c_oe;
  assign OUT_PIN_D = q.pins.d_o;
  assign OUT_PIN_D_OE = q.pins.d_oe;
  assign ERR_PIN_O = q.pins.err_o;
  assign ERR_PIN_OE = q.pins.err_oe;
  assign SWITCHED_GROUND_PIN_CLOSE = q.pins.sw;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chop_pair_a: assert property ( // RULE1
    CONV_DONE && !start_ev && CHOP_EN && q.st == S_CONV && q.have_prev
    |=> RESULT_VALID && RESULT == $past(avg) && CONV_SWAP != $past(q.swap))
    else $error("chop pair did not give its average");
  chop_first_a: assert property ( // RULE2
    CONV_DONE && !start_ev && CHOP_EN && q.st == S_CONV && !q.have_prev
    |=> !RESULT_VALID && CONV_GO)
    else $error("chop gave a result after one conversion");
  por_hold_a: assert property ( // RULE5
    FLAGS.power_on_flag && !POR_CLR |=> FLAGS.power_on_flag)
    else $error("power-on flag lost without clear");
  uvlo_set_a: assert property ( // RULE6
    q.f[AI_UVLO] |=> FLAGS.undervoltage_flag)
    else $error("undervoltage flag not set");
  ready_time_a: assert property ( // RULE7
    $rose(FLAGS.ready) |-> $past(q.su) == 16'(STARTUP_CYC))
    else $error("ready raised at wrong time");
  rail_hold_a: assert property ( // RULE9
    !CONV_DONE |=> $stable(FLAGS.pos_output_rail_flag) && $stable(FLAGS.neg_output_rail_flag))
    else $error("rail flags moved inside a conversion");
  range_force_a: assert property ( // RULE12
    CONV_DONE && CONV_UNDER && q.st == S_CONV && !start_ev
    |=> FLAGS.range_err && ($past(CHOP_EN) ? q.prev == '0 : (RESULT_VALID && RESULT == '0)))
    else $error("underrange code not forced to zero");
  crc_reject_a: assert property ( // RULE18
    fr_end && !is_rd && crc_on && l.cnt >= 6'h10 && l.crc_w != CRC_GOOD
    |=> !WR_APPLY && FLAGS.crc_err)
    else $error("bad checksum write was applied");

endmodule // adcd_top
`default_nettype wire

// [src/adcd_dummy_unused.sv]
// empty source, no logic lives here
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [testbench/adcd_host_model.sv]
// serial host model: framed transfers, link clock stopped between frames
`timescale 1ns/1ps
`default_nettype none
module adcd_host_model (
  output var logic LINK_CLK,
  output var logic LINK_CS_N,
  output var logic LINK_DIN,
  output var logic LINK_DOUT
);
  initial begin
    LINK_CLK = 1'b0;
    LINK_CS_N = 1'b1;
    LINK_DIN = 1'b0;
    LINK_DOUT = 1'b0;
  end
  // dout mirrors din so read checksums cover known bits
  task automatic frame(input logic [39:0] bits, input int n);
    #1.7 LINK_CS_N = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #3 LINK_DIN = bits[i];
      LINK_DOUT = bits[i];
      #3 LINK_CLK = 1'b1;
      #6 LINK_CLK = 1'b0;
    end
    #3 LINK_CS_N = 1'b1;
    // released lines flip so a held value cannot pass
    LINK_DIN = ~LINK_DIN;
    LINK_DOUT = ~LINK_DOUT;
    #60;
  endtask
endmodule // adcd_host_model
`default_nettype wire

// [testbench/adcd_top_bench.sv]
// self-checking bench for the converter support logic
`timescale 1ns/1ps
`default_nettype none
module adcd_top_bench
  import adcd_pkg::*;
;
  logic CLK, RST_N, LINK_CLK, LINK_CS_N, LINK_DIN, LINK_DOUT, CHOP_EN, CONT_MODE, START_PIN, START_CMD, CONV_GO;
  logic CONV_SWAP, CONV_DONE, CONV_OVER, CONV_UNDER, RESULT_VALID, UVLO_DET, AMP_BYPASS, REF_LOW_300, REF_LOW_THIRD;
  logic REF_MON_EN, REF_THR_SEL, POR_CLR, UVLO_CLR, CRC_ERR_CLR, REG_CHECK_EN, WR_APPLY, BIDIR_PIN_A_O, ext_a, ext_b;
  logic BIDIR_PIN_A_OE, BIDIR_PIN_B_O, BIDIR_PIN_B_OE, PIN_A_READ, PIN_B_READ, OUT_PIN_C, OUT_PIN_C_OE, OUT_PIN_D;
  logic OUT_PIN_D_OE, ERR_PIN_O, ERR_PIN_OE, BRIDGE_SWITCH_CONTROL, SWITCHED_GROUND_PIN_CLOSE;
  logic [1:0] CRC_MODE, WR_LEN;
  logic [3:0] RAIL_PGA, RAIL_ADC;
  logic [4:0] PIN_DATA;
  logic [7:0] LINK_RD_CRC, WR_CMD, PIN_CONTROL_REGISTER;
  logic [23:0] CONV_CODE, RESULT, WR_DATA, d;
  logic [39:0] v;
  logic [63:0] REG_IMAGE;
  adcd_flags_s FLAGS;
  int err_total = 0, check_count = 0, cyc = 0, vcount = 0, acount = 0, n;
  wire BIDIR_PIN_A_I = BIDIR_PIN_A_OE ? BIDIR_PIN_A_O : ext_a;
  wire BIDIR_PIN_B_I = BIDIR_PIN_B_OE ? BIDIR_PIN_B_O : ext_b;

  adcd_top i_adcd_top (
    .CLK, .RST_N, .LINK_CLK, .LINK_CS_N, .LINK_DIN, .LINK_DOUT, .LINK_RD_CRC, .CRC_MODE, .CHOP_EN, .CONT_MODE,
    .START_PIN, .START_CMD, .CONV_GO, .CONV_SWAP, .CONV_DONE, .CONV_CODE, .CONV_OVER, .CONV_UNDER, .RESULT,
    .RESULT_VALID, .UVLO_DET, .RAIL_PGA, .RAIL_ADC, .AMP_BYPASS, .REF_LOW_300, .REF_LOW_THIRD, .REF_MON_EN,
    .REF_THR_SEL, .POR_CLR, .UVLO_CLR, .CRC_ERR_CLR, .REG_CHECK_EN, .REG_IMAGE, .FLAGS, .WR_APPLY, .WR_CMD,
    .WR_DATA, .WR_LEN, .PIN_CONTROL_REGISTER, .PIN_DATA, .BIDIR_PIN_A_I, .BIDIR_PIN_A_O, .BIDIR_PIN_A_OE,
    .BIDIR_PIN_B_I, .BIDIR_PIN_B_O, .BIDIR_PIN_B_OE, .PIN_A_READ, .PIN_B_READ, .OUT_PIN_C, .OUT_PIN_C_OE,
    .OUT_PIN_D, .OUT_PIN_D_OE, .ERR_PIN_O, .ERR_PIN_OE, .BRIDGE_SWITCH_CONTROL, .SWITCHED_GROUND_PIN_CLOSE);
  adcd_host_model i_adcd_host_model (.LINK_CLK, .LINK_CS_N, .LINK_DIN, .LINK_DOUT);

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // pulse counters, plus a ceiling well above the expected run
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (RESULT_VALID === 1'b1) vcount <= vcount + 1;
    if (WR_APPLY === 1'b1) acount <= acount + 1;
    if (cyc == 10000) begin
      err_total++;
      conclude();
    end
  end

  task automatic tick();
    @(posedge CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic waitfor(ref logic s);
    for (int k = 0; k < 60 && s !== 1'b1; k++) tick();
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  function automatic logic [7:0] mk_crc(input logic [39:0] x, input int len);
    logic [7:0] c;
    c = 8'h00;
    for (int i = len - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ x[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // plays the conversion engine: answer each go after a few cycles
  task automatic conv(input logic [23:0] code, input logic [1:0] f, input logic sw);
    waitfor(CONV_GO);
    chk("go", 1, CONV_GO);
    chk("swap", sw, CONV_SWAP);
    repeat (6) tick();
    CONV_DONE = 1'b1;
    CONV_CODE = code;
    {CONV_OVER, CONV_UNDER} = f;
    tick();
    CONV_DONE = 1'b0;
  endtask
  task automatic pair(input logic pin, input logic [23:0] a, input logic [1:0] fa, input logic [23:0] b,
                      input logic [1:0] fb, input logic [23:0] exp);
    if (pin) START_PIN = 1'b1;
    else START_CMD = 1'b1;
    tick();
    START_CMD = 1'b0;
    conv(a, fa, 1'b0);
    conv(b, fb, 1'b1);
    waitfor(RESULT_VALID);
    chk("result", exp, RESULT);
    START_PIN = 1'b0;
    tick();
  endtask

  initial begin
    {CHOP_EN, CONT_MODE, START_PIN, START_CMD, CONV_DONE, CONV_OVER, CONV_UNDER, UVLO_DET, AMP_BYPASS} = '0;
    {REF_LOW_300, REF_LOW_THIRD, REF_MON_EN, REF_THR_SEL, POR_CLR, UVLO_CLR, CRC_ERR_CLR, REG_CHECK_EN} = '0;
    {CRC_MODE, CONV_CODE, RAIL_PGA, RAIL_ADC, REG_IMAGE, PIN_CONTROL_REGISTER, PIN_DATA} = '0;
    {BRIDGE_SWITCH_CONTROL, ext_a, ext_b} = '0;
    RST_N = 1'b0;
    repeat (5) tick();
    chk("por_rst", 1, FLAGS.power_on_flag);
    RST_N = 1'b1;
    repeat (200) tick();
    chk("ready_early", 0, FLAGS.ready);
    repeat (60) tick();
    chk("ready", 1, FLAGS.ready);
    chk("por_held", 1, FLAGS.power_on_flag);
    pulse(POR_CLR);
    chk("por_clr", 0, FLAGS.power_on_flag);
    PIN_CONTROL_REGISTER = 8'hbf;
    PIN_DATA = 5'h15;
    BRIDGE_SWITCH_CONTROL = 1'b1;
    repeat (3) tick();
    chk("pins_out", 10'h377, {BIDIR_PIN_A_O, BIDIR_PIN_A_OE, BIDIR_PIN_B_O, BIDIR_PIN_B_OE, OUT_PIN_C,
        OUT_PIN_C_OE, OUT_PIN_D, OUT_PIN_D_OE, ERR_PIN_O, ERR_PIN_OE});
    chk("switch_on", 1, SWITCHED_GROUND_PIN_CLOSE);
    {PIN_CONTROL_REGISTER, ext_a, ext_b, BRIDGE_SWITCH_CONTROL} = {8'h30, 1'b0, 1'b1, 1'b0};
    repeat (8) tick();
    chk("pins_in", 8'h02, {BIDIR_PIN_A_OE, BIDIR_PIN_B_OE, OUT_PIN_C_OE, OUT_PIN_D_OE, ERR_PIN_OE,
        PIN_A_READ, PIN_B_READ, SWITCHED_GROUND_PIN_CLOSE});
    UVLO_DET = 1'b1;
    repeat (6) tick();
    chk("uvlo", 1, FLAGS.undervoltage_flag);
    UVLO_DET = 1'b0;
    repeat (4) tick();
    pulse(UVLO_CLR);
    chk("uvlo_clr", 0, FLAGS.undervoltage_flag);
    REG_IMAGE = 64'h0123456789abcdef;
    REG_CHECK_EN = 1'b1;
    repeat (3) tick();
    chk("reg_ok", 0, FLAGS.reg_err);
    REG_IMAGE[5] = 1'b0;
    repeat (3) tick();
    chk("reg_bad", 1, FLAGS.reg_err);
    REG_CHECK_EN = 1'b0;
    CHOP_EN = 1'b1;
    PIN_CONTROL_REGISTER = 8'h40;
    pair(0, 24'h000100, 2'b00, 24'h000300, 2'b00, 24'h000200);
    chk("range_ok", 0, FLAGS.range_err);
    pair(0, 24'h123456, 2'b01, 24'h000001, 2'b10, 24'h7fffff);
    chk("range_set", 1, FLAGS.range_err);
    chk("err_pin", 2'b01, {ERR_PIN_O, ERR_PIN_OE});
    pair(0, 24'h000010, 2'b00, 24'h000030, 2'b00, 24'h000020);
    chk("range_clr", 0, FLAGS.range_err);
    REF_MON_EN = 1'b1;
    REF_LOW_300 = 1'b1;
    for (int c = 0; c < 2; c++) begin
      {AMP_BYPASS, REF_THR_SEL, RAIL_PGA, RAIL_ADC} = {c[0], c[0], 4'h1, 4'h8};
      repeat (6) tick();
      chk("rail_early", 0, {FLAGS.pos_output_rail_flag, FLAGS.neg_output_rail_flag});
      pair(c[0], 24'h10, 2'b00, 24'h20, 2'b00, 24'h18);
      chk("rail", c ? 4'h2 : 4'h4, {FLAGS.pos_output_rail_flag, FLAGS.neg_output_rail_flag});
      chk("ref_low", !c, FLAGS.ref_low);
      {RAIL_PGA, RAIL_ADC} = 8'h00;
      repeat (6) tick();
      // rail bits left pending show at the next conversion end; the first pair already clears them, the second repeats it
      pair(0, 24'h10, 2'b00, 24'h20, 2'b00, 24'h18);
      pair(0, 24'h10, 2'b00, 24'h20, 2'b00, 24'h18);
      chk("rail_clr", 0, {FLAGS.pos_output_rail_flag, FLAGS.neg_output_rail_flag});
    end
    CONT_MODE = 1'b1;
    n = vcount;
    // go stands one cycle, so the start must not be followed by an extra tick
    START_CMD = 1'b1;
    tick();
    START_CMD = 1'b0;
    for (int i = 0; i < 4; i++) begin
      conv(24'h40 * 24'(i + 1), 2'b00, i[0]);
      if (i > 0) begin
        waitfor(RESULT_VALID);
        chk("cont", 24'h40 * 24'(i) + 24'h20, RESULT);
      end
    end
    CONT_MODE = 1'b0;
    tick();
    chk("cont_cnt", 3, vcount - n);
    CHOP_EN = 1'b0;
    START_CMD = 1'b1;
    tick();
    START_CMD = 1'b0;
    conv(24'h123456, 2'b01, 1'b0);
    chk("single", 0, RESULT);
    CRC_MODE = CRC_POLYNOMIAL;
    for (int b = 1; b <= 3; b++) begin
      d = 24'ha1b2c3 & (24'hffffff >> (8 * (3 - b)));
      v = (40'h05 << (8 * b)) | 40'(d);
      n = acount;
      i_adcd_host_model.frame((v << 8) | 40'(mk_crc(v, 8 + 8 * b)), 16 + 8 * b);
      tick();
      chk("wr_cnt", 1, acount - n);
      chk("wr_cmd", 8'h05, WR_CMD);
      chk("wr_data", d, WR_DATA);
      chk("wr_len", b - 1, WR_LEN);
      chk("crc_ok", 0, FLAGS.crc_err);
    end
    n = acount;
    v = 40'h055a5a5a;
    i_adcd_host_model.frame((v << 8) | 40'(mk_crc(v, 32) ^ 8'h01), 40);
    tick();
    chk("bad_cnt", 0, acount - n);
    chk("bad_flag", {1'b1, 24'ha1b2c3}, {FLAGS.crc_err, WR_DATA});
    pulse(CRC_ERR_CLR);
    for (int m = 1; m <= 2; m++) begin
      CRC_MODE = 2'(m);
      i_adcd_host_model.frame(40'h42a5c30f11, 40);
      tick();
      chk("rd_crc", m == 1 ? 8'h42 ^ 8'ha5 ^ 8'hc3 ^ 8'h0f ^ 8'h11 : mk_crc(40'h42a5c30f11, 40), LINK_RD_CRC);
    end
    chk("rd_no_wr", 0, acount - n);
    conclude();
  end
endmodule // adcd_top_bench
`default_nettype wire
